/* logic/tic_cfg.svh */
`ifndef TIC_CFG_SVH
`define TIC_CFG_SVH

// ****************************************
// register byte offsets
// ****************************************
`define TIC_OFS_CTRL0   8'h00
`define TIC_OFS_CTRL1   8'h04
`define TIC_OFS_MODE    8'h08
`define TIC_OFS_COUNT   8'h0c
`define TIC_OFS_GRC0    8'h10
`define TIC_OFS_GRB1    8'h14
`define TIC_OFS_STATUS  8'h18

// ****************************************
// field positions
// ****************************************
`define TIC_FIELD_W     4
`define TIC_CTRL_W      8
`define TIC_REGC_LSB    0
`define TIC_REGB_LSB    4
`define TIC_MODE_BUFA   0
`define TIC_MODE_RUN    1
`define TIC_MODE_CLR    2
`define TIC_MODE_W      2
`define TIC_ST_CAP0     0
`define TIC_ST_MAT0     1
`define TIC_ST_CAP1     2
`define TIC_ST_MAT1     3
`define TIC_ST_PIN0     4
`define TIC_ST_PIN1     5
`define TIC_FLAG_W      4

// ****************************************
// reset values
// ****************************************
`define TIC_CTRL_RST    8'h00
`define TIC_MODE_RST    2'h0

// ****************************************
// field code pieces
// ****************************************
`define TIC_BIT_CAPT    3
`define TIC_BIT_HIGH    2
`define TIC_BIT_BOTH    1
`define TIC_BIT_FALL    0
`define TIC_ACT_LOW     2'h1
`define TIC_ACT_HIGH    2'h2
`define TIC_ACT_TOGGLE  2'h3
`define TIC_ACT_NONE    2'h0

// ****************************************
// bus encodings
// ****************************************
`define TIC_ADDR_W      8
`define TIC_HTRANS_NSEQ 1

`endif

/* logic/tic_pkg.sv */
package tic_pkg;

  // what a general register does for its field code
  typedef enum logic [1:0]
  {
    TIC_NONE = 2'b00,
    TIC_OCMP = 2'b01,
    TIC_ICAP = 2'b10
  } tic_func_t;

  // field code to register function, blocked by buffer use
  function automatic tic_func_t tic_decode(input logic [3:0] field, input logic inhibit);
    tic_func_t f;
    f = TIC_NONE;
    if (inhibit)
      f = TIC_NONE;
    else if (!field[3])
      f = (field[1:0] != 2'h0) ? TIC_OCMP : TIC_NONE;
    else if (!field[2])
      f = TIC_ICAP;
    else
      f = TIC_NONE;
    return f;
  endfunction

endpackage

/* logic/tic_chan_if.sv */
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// one channel's link between top and channel
// ****************************************
interface tic_chan_if #(parameter int CNT_W = 16);
  logic [3:0]       field;
  logic             inhibit;
  logic             pinIn;
  logic             countTick;
  logic [CNT_W-1:0] count;
  logic             grWrEn;
  logic [CNT_W-1:0] grWrData;
  logic [CNT_W-1:0] gr;
  logic             pinOut;
  logic             pinOe_b;
  logic             capEvent;
  logic             matchEvent;

  modport top (output field, inhibit, pinIn, countTick, count, grWrEn, grWrData,
               input gr, pinOut, pinOe_b, capEvent, matchEvent);
  modport chan (input field, inhibit, pinIn, countTick, count, grWrEn, grWrData,
                output gr, pinOut, pinOe_b, capEvent, matchEvent);
endinterface

`default_nettype wire

/* logic/tic_channel.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tic_cfg.svh"

// ****************************************
// one general register with its pin
// ****************************************
module tic_channel
(
  input  wire logic  clk,   // timer clock
  input  wire logic  rst_b, // synchronised reset, active low
  tic_chan_if.chan   ch     // field, counter, pin and bus side
);

  tic_pkg::tic_func_t func;
  logic [4:0]         prevCfg;
  logic               pinPrev;
  logic               cfgChange;
  logic               rise;
  logic               fall;
  logic               capHit;
  logic               matchHit;

  // decode of the current field
  always_comb
  begin
    func = tic_pkg::tic_decode(ch.field, ch.inhibit); // RL10 RL11
  end

  // edge and match detection
  always_comb
  begin
    cfgChange = ({ch.inhibit, ch.field} != prevCfg);
    rise      = ch.pinIn & ~pinPrev;
    fall      = ~ch.pinIn & pinPrev;
    capHit    = 1'b0;
    if (func == tic_pkg::TIC_ICAP)
    begin
      if (ch.field[`TIC_BIT_BOTH])
        capHit = rise | fall; // RL8
      else if (ch.field[`TIC_BIT_FALL])
        capHit = fall; // RL7
      else
        capHit = rise; // RL6
    end
    matchHit = (func == tic_pkg::TIC_OCMP) & ch.countTick & (ch.count == ch.gr);
  end

  // history of configuration and pin
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prevCfg <= 5'h00;
      pinPrev <= 1'b0;
    end
    else
    begin
      prevCfg <= {ch.inhibit, ch.field};
      pinPrev <= ch.pinIn;
    end
  end

  // general register: capture beats a bus write
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      ch.gr <= '0;
    else if (capHit)
      ch.gr <= ch.count; // RL6 RL7 RL8
    else if (ch.grWrEn)
      ch.gr <= ch.grWrData;
  end

  // pin level: initial level on setup, action on match
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      ch.pinOut <= 1'b0;
    else if (func == tic_pkg::TIC_OCMP && cfgChange)
      ch.pinOut <= ch.field[`TIC_BIT_HIGH]; // RL1 RL2
    else if (matchHit)
    begin
      case (ch.field[1:0])
        `TIC_ACT_LOW:    ch.pinOut <= 1'b0;        // RL3
        `TIC_ACT_HIGH:   ch.pinOut <= 1'b1;        // RL4
        `TIC_ACT_TOGGLE: ch.pinOut <= ~ch.pinOut;  // RL5
        default:         ch.pinOut <= ch.pinOut;
      endcase
    end
  end

  // drive enable and event pulses
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ch.pinOe_b    <= 1'b1;
      ch.capEvent   <= 1'b0;
      ch.matchEvent <= 1'b0;
    end
    else
    begin
      ch.pinOe_b    <= (func != tic_pkg::TIC_OCMP); // RL11
      ch.capEvent   <= capHit;
      ch.matchEvent <= matchHit;
    end
  end

endmodule

`default_nettype wire

/* logic/tic_io_decode.sv */
// Our own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "tic_cfg.svh"

// Functional notes
// RL1 - A top-clear, bit-2-clear nonzero code makes the register an output compare with pin starting at 0.
// RL2 - A top-clear, bit-2-set code with nonzero low bits starts the pin at 1 in output compare.
// RL3 - Low bits 01 drive the pin low on each compare match.
// RL4 - Low bits 10 drive the pin high on each compare match.
// RL5 - Low bits 11 invert the pin on each compare match.
// RL6 - Code 1000 captures the counter on a rising pin edge.
// RL7 - Code 1001 captures the counter on a falling pin edge.
// RL8 - Codes 101x capture the counter on both pin edges.
// RL9 - Channel 1 register B captures from its own B-side pin.
// RL10 - With buffer-A mode set, the channel 0 register C field is ignored entirely.
// RL11 - Codes 0000 and 0100 leave the pin undriven, and codes 11xx are prohibited and do nothing.
module tic_io_decode #(
  parameter int CNT_W = 16
)
(
  input  wire logic        mclk,        // 25 MHz timer clock
  input  wire logic        rst_b,       // asynchronous reset, active low
  input  wire logic        hsel,        // slave select
  input  wire logic [31:0] haddr,       // byte address
  input  wire logic [1:0]  htrans,      // transfer type
  input  wire logic        hwrite,      // write when high
  input  wire logic [2:0]  hsize,       // word only
  input  wire logic [31:0] hwdata,      // write data
  input  wire logic        hready,      // bus ready in
  output var  logic [31:0] hrdata,      // read data
  output var  logic        hreadyout,   // always ready
  output var  logic        hresp,       // always okay
  input  wire logic        ch0PinAIn,   // channel 0 pin A level
  output var  logic        ch0PinAOut,  // channel 0 pin A drive value
  output var  logic        ch0PinAOe_b, // low while driving pin A
  input  wire logic        ch1PinBIn,   // channel 1 pin B level
  output var  logic        ch1PinBOut,  // channel 1 pin B drive value
  output var  logic        ch1PinBOe_b  // low while driving pin B
);

  // ****************************************
  // declarations
  // ****************************************
  logic                   rstMeta_b;
  logic                   rstSync_b;
  logic [1:0]             pinMeta;
  logic [1:0]             pinSync;
  logic [`TIC_CTRL_W-1:0] ch0IoCtrlLow;
  logic [`TIC_CTRL_W-1:0] ch1IoCtrl;
  logic [`TIC_MODE_W-1:0] ch0ModeReg;
  logic [CNT_W-1:0]       count;
  logic [`TIC_FLAG_W-1:0] flags;
  logic [`TIC_FLAG_W-1:0] flagSet;
  logic                   dpWrite;
  logic [`TIC_ADDR_W-1:0] dpAddr;
  logic                   apValid;
  logic [`TIC_ADDR_W-1:0] apAddr;
  logic                   counterClear;
  logic [31:0]            next_hrdata;

  tic_chan_if #(.CNT_W(CNT_W)) chIf[2] ();

  // ****************************************
  // reset release
  // ****************************************

  // two-stage release of the reset
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rstMeta_b <= 1'b0;
      rstSync_b <= 1'b0;
    end
    else
    begin
      rstMeta_b <= 1'b1;
      rstSync_b <= rstMeta_b;
    end
  end

  // ****************************************
  // pin input synchronisers
  // ****************************************

  // two flops per pin before any edge logic
  always_ff @(posedge mclk or negedge rstSync_b)
  begin
    if (!rstSync_b)
    begin
      pinMeta <= 2'h0;
      pinSync <= 2'h0;
    end
    else
    begin
      pinMeta <= {ch1PinBIn, ch0PinAIn}; // RL9
      pinSync <= pinMeta;
    end
  end

  // ****************************************
  // bus address phase
  // ****************************************

  // a transfer is taken when selected, nonsequential or sequential, and ready
  always_comb
  begin
    apValid = hsel & htrans[`TIC_HTRANS_NSEQ] & hready;
    apAddr  = haddr[`TIC_ADDR_W-1:0];
  end

  // remember a write for its data phase
  always_ff @(posedge mclk or negedge rstSync_b)
  begin
    if (!rstSync_b)
    begin
      dpWrite <= 1'b0;
      dpAddr  <= '0;
    end
    else
    begin
      dpWrite <= apValid & hwrite;
      dpAddr  <= apAddr;
    end
  end

  // zero wait states, always okay
  always_ff @(posedge mclk or negedge rstSync_b)
  begin
    if (!rstSync_b)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ****************************************
  // control registers
  // ****************************************

  // io control fields written in the data phase
  always_ff @(posedge mclk or negedge rstSync_b)
  begin
    if (!rstSync_b)
    begin
      ch0IoCtrlLow <= `TIC_CTRL_RST;
      ch1IoCtrl    <= `TIC_CTRL_RST;
    end
    else if (dpWrite)
    begin
      if (dpAddr == `TIC_OFS_CTRL0)
        ch0IoCtrlLow <= hwdata[`TIC_CTRL_W-1:0];
      if (dpAddr == `TIC_OFS_CTRL1)
        ch1IoCtrl <= hwdata[`TIC_CTRL_W-1:0];
    end
  end

  // mode register: buffer-A use and counter run
  always_ff @(posedge mclk or negedge rstSync_b)
  begin
    if (!rstSync_b)
      ch0ModeReg <= `TIC_MODE_RST;
    else if (dpWrite && dpAddr == `TIC_OFS_MODE)
      ch0ModeReg <= hwdata[`TIC_MODE_W-1:0];
  end

  // one-shot counter clear on a mode write with the clear bit set
  always_comb
  begin
    counterClear = dpWrite & (dpAddr == `TIC_OFS_MODE) & hwdata[`TIC_MODE_CLR];
  end

  // ****************************************
  // timer counter
  // ****************************************

  // free count while running, clear on request
  always_ff @(posedge mclk or negedge rstSync_b)
  begin
    if (!rstSync_b)
      count <= '0;
    else if (counterClear)
      count <= '0;
    else if (ch0ModeReg[`TIC_MODE_RUN])
      count <= count + 1'b1;
  end

  // ****************************************
  // channels
  // ****************************************

  // channel 0 register C on pin A, channel 1 register B on pin B
  always_comb
  begin
    chIf[0].field    = ch0IoCtrlLow[`TIC_REGC_LSB +: `TIC_FIELD_W];
    chIf[0].inhibit  = ch0ModeReg[`TIC_MODE_BUFA]; // RL10
    chIf[0].grWrEn   = dpWrite & (dpAddr == `TIC_OFS_GRC0);
    chIf[1].field    = ch1IoCtrl[`TIC_REGB_LSB +: `TIC_FIELD_W];
    chIf[1].inhibit  = 1'b0;
    chIf[1].grWrEn   = dpWrite & (dpAddr == `TIC_OFS_GRB1);
  end

  // shared wiring and instances
  generate
    for (genvar i = 0; i < 2; i++)
    begin : gChan
      assign chIf[i].pinIn     = pinSync[i]; // RL9
      assign chIf[i].countTick = ch0ModeReg[`TIC_MODE_RUN];
      assign chIf[i].count     = count;
      assign chIf[i].grWrData  = hwdata[CNT_W-1:0];
      tic_channel uChan
      (
        .clk   (mclk),
        .rst_b (rstSync_b),
        .ch    (chIf[i])
      );
    end
  endgenerate

  // ****************************************
  // pin outputs
  // ****************************************

  // channel flops drive the pins directly
  always_comb
  begin
    ch0PinAOut  = chIf[0].pinOut;
    ch0PinAOe_b = chIf[0].pinOe_b;
    ch1PinBOut  = chIf[1].pinOut;
    ch1PinBOe_b = chIf[1].pinOe_b;
  end

  // ****************************************
  // status flags
  // ****************************************

  // capture and match events
  always_comb
  begin
    flagSet                = '0;
    flagSet[`TIC_ST_CAP0]  = chIf[0].capEvent;
    flagSet[`TIC_ST_MAT0]  = chIf[0].matchEvent;
    flagSet[`TIC_ST_CAP1]  = chIf[1].capEvent;
    flagSet[`TIC_ST_MAT1]  = chIf[1].matchEvent;
  end

  // sticky flags, write one to clear, set wins
  always_ff @(posedge mclk or negedge rstSync_b)
  begin
    if (!rstSync_b)
      flags <= '0;
    else if (dpWrite && dpAddr == `TIC_OFS_STATUS)
      flags <= (flags & ~hwdata[`TIC_FLAG_W-1:0]) | flagSet;
    else
      flags <= flags | flagSet;
  end

  // ****************************************
  // read data
  // ****************************************

  // read mux in the address phase
  always_comb
  begin
    next_hrdata = 32'h0000_0000;
    if (apValid && !hwrite)
    begin
      case (apAddr)
        `TIC_OFS_CTRL0:  next_hrdata[`TIC_CTRL_W-1:0] = ch0IoCtrlLow;
        `TIC_OFS_CTRL1:  next_hrdata[`TIC_CTRL_W-1:0] = ch1IoCtrl;
        `TIC_OFS_MODE:   next_hrdata[`TIC_MODE_W-1:0] = ch0ModeReg;
        `TIC_OFS_COUNT:  next_hrdata[CNT_W-1:0]       = count;
        `TIC_OFS_GRC0:   next_hrdata[CNT_W-1:0]       = chIf[0].gr;
        `TIC_OFS_GRB1:   next_hrdata[CNT_W-1:0]       = chIf[1].gr;
        `TIC_OFS_STATUS:
        begin
          next_hrdata[`TIC_FLAG_W-1:0] = flags;
          next_hrdata[`TIC_ST_PIN0]    = pinSync[0];
          next_hrdata[`TIC_ST_PIN1]    = pinSync[1];
        end
        default:         next_hrdata = 32'h0000_0000;
      endcase
    end
  end

  // read data held for the data phase
  always_ff @(posedge mclk or negedge rstSync_b)
  begin
    if (!rstSync_b)
      hrdata <= 32'h0000_0000;
    else
      hrdata <= next_hrdata;
  end

endmodule

`default_nettype wire

/* test/tic_checker.sv */
`timescale 1ns/1ps
`default_nettype none

// *****
// port checker
// *****
module tic_checker #(
  parameter int CNT_W = 16
)
(
  input wire logic        mclk,        // clock
  input wire logic        rst_b,       // reset
  input wire logic        hsel,        // select
  input wire logic [31:0] haddr,       // address
  input wire logic [1:0]  htrans,      // type
  input wire logic        hwrite,      // write
  input wire logic [2:0]  hsize,       // size
  input wire logic [31:0] hwdata,      // wdata
  input wire logic        hready,      // ready in
  input wire logic [31:0] hrdata,      // rdata
  input wire logic        hreadyout,   // ready out
  input wire logic        hresp,       // response
  input wire logic        ch0PinAIn,   // pin a in
  input wire logic        ch0PinAOut,  // pin a out
  input wire logic        ch0PinAOe_b, // pin a enable
  input wire logic        ch1PinBIn,   // pin b in
  input wire logic        ch1PinBOut,  // pin b out
  input wire logic        ch1PinBOe_b  // pin b enable
);
  logic       wrA, rdPh, bufA, dA, dB;
  logic [7:0] wAdr;
  logic [3:0] fC, fB;

  // shadow of the fields as software wrote them
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wrA  <= 1'b0;
      rdPh <= 1'b0;
      wAdr <= 8'h00;
      fC   <= 4'h0;
      fB   <= 4'h0;
      bufA <= 1'b0;
    end
    else
    begin
      wrA  <= hsel & htrans[1] & hready & hwrite;
      rdPh <= hsel & htrans[1] & hready & !hwrite;
      wAdr <= haddr[7:0];
      if (wrA && wAdr == 8'h00)
        fC <= hwdata[3:0];
      if (wrA && wAdr == 8'h04)
        fB <= hwdata[7:4];
      if (wrA && wAdr == 8'h08)
        bufA <= hwdata[0];
    end
  end

  // expected drive of each pin
  assign dA = !bufA && !fC[3] && fC[1:0] != 2'h0;
  assign dB = !fB[3] && fB[1:0] != 2'h0;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  AST_A_DRIVE: assert property (
    ch0PinAOe_b == !$past(dA)) else $error("pin a enable wrong");
  AST_B_DRIVE: assert property (
    ch1PinBOe_b == !$past(dB)) else $error("pin b enable wrong");
  AST_A_INIT: assert property (
    $fell(ch0PinAOe_b) |-> ch0PinAOut == $past(fC[2])) else $error("pin a start wrong");
  AST_B_INIT: assert property (
    $fell(ch1PinBOe_b) |-> ch1PinBOut == $past(fB[2])) else $error("pin b start wrong");
  AST_A_LOW: assert property (
    !ch0PinAOe_b && !$past(ch0PinAOe_b) && $past(fC) == $past(fC, 2)
    && $past(fC[1:0]) == 2'h1 |-> !$rose(ch0PinAOut)) else $error("pin a rose");
  AST_B_HIGH: assert property (
    !ch1PinBOe_b && !$past(ch1PinBOe_b) && $past(fB) == $past(fB, 2)
    && $past(fB[1:0]) == 2'h2 |-> !$fell(ch1PinBOut)) else $error("pin b fell");
  AST_B_CAPT: assert property (
    $past(fB[3]) |-> ch1PinBOe_b) else $error("pin b driven in capture");
  AST_RDATA: assert property (
    !rdPh |-> hrdata == 32'h0 && hreadyout && !hresp) else $error("bus answer wrong");
endmodule

bind tic_io_decode tic_checker #(.CNT_W(CNT_W)) u_chk
(
  .mclk(mclk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .ch0PinAIn(ch0PinAIn), .ch0PinAOut(ch0PinAOut),
  .ch0PinAOe_b(ch0PinAOe_b), .ch1PinBIn(ch1PinBIn), .ch1PinBOut(ch1PinBOut),
  .ch1PinBOe_b(ch1PinBOe_b)
);

`default_nettype wire

/* test/tic_pin_model.sv */
`timescale 1ns/1ps
`default_nettype none

// *****
// far side of the two pins
// *****
module tic_pin_model
(
  input  wire logic aLevel, // far side level, pin a
  input  wire logic bLevel, // far side level, pin b
  input  wire logic aOut,   // device value, pin a
  input  wire logic aOe_b,  // device enable, pin a
  input  wire logic bOut,   // device value, pin b
  input  wire logic bOe_b,  // device enable, pin b
  output var  logic aIn,    // wire level, pin a
  output var  logic bIn     // wire level, pin b
);
  // device wins while it drives
  assign aIn = aOe_b ? aLevel : aOut;
  assign bIn = bOe_b ? bLevel : bOut;
endmodule

`default_nettype wire

/* test/test_timer_io_control_decode.sv */
`timescale 1ns/1ps
`default_nettype none

// *****
// bench
// *****
module test_timer_io_control_decode;
  logic        mclk, rst_b, hwrite, hrdy, hresp, setA, setB;
  logic        aIn, aOut, aOe_b, bIn, bOut, bOe_b;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int          nMismatch, checkCount;

  tic_io_decode #(.CNT_W(16)) u_dut
  (
    .mclk(mclk), .rst_b(rst_b), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata),
    .hreadyout(hrdy), .hresp(hresp), .ch0PinAIn(aIn), .ch0PinAOut(aOut),
    .ch0PinAOe_b(aOe_b), .ch1PinBIn(bIn), .ch1PinBOut(bOut), .ch1PinBOe_b(bOe_b)
  );

  tic_pin_model u_pins
  (
    .aLevel(setA), .bLevel(setB), .aOut(aOut), .aOe_b(aOe_b),
    .bOut(bOut), .bOe_b(bOe_b), .aIn(aIn), .bIn(bIn)
  );

  // verdict
  task automatic completeRun();
    $display("checks %0d mismatches %0d", checkCount, nMismatch);
    if (nMismatch == 0 && checkCount > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp)
    begin
      nMismatch++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // bounded wait for ready at an edge
  task automatic waitRdy();
    for (int i = 0; i < 20; i++)
    begin
      @(posedge mclk);
      if (hrdy === 1'b1)
        return;
    end
    nMismatch++;
    completeRun();
  endtask

  // one single word transfer
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    waitRdy();
    htrans <= 2'h0;
    hwdata <= d;
    waitRdy();
    rd = hrdata;
  endtask

  // reset values, width, unmapped place
  task automatic testRegs();
    for (int i = 0; i < 8; i++)
    begin
      xfer(8'(i * 4), 1'b0, 32'h0);
      chk(rd, 32'h0);
    end
    xfer(8'h1c, 1'b1, 32'hffffffff);
    xfer(8'h10, 1'b1, 32'hffffffff);
    xfer(8'h1c, 1'b0, 32'h0);
    chk(rd, 32'h0);
    xfer(8'h10, 1'b0, 32'h0);
    chk(rd, 32'hffff);
    xfer(8'h04, 1'b1, 32'h5a);
    xfer(8'h04, 1'b0, 32'h0);
    chk(rd, 32'h5a);
    $display("regs done");
  endtask

  // every code: drive and start level
  task automatic testInit();
    logic drv;
    for (int c = 0; c < 16; c++)
    begin
      xfer(8'h00, 1'b1, 32'(c));
      xfer(8'h04, 1'b1, 32'(c) << 4);
      cyc(2);
      drv = c < 8 && c % 4 != 0;
      chk(aOe_b, !drv);
      chk(bOe_b, !drv);
      if (drv)
      begin
        chk(aOut, c[2]);
        chk(bOut, c[2]);
      end
    end
    $display("init done");
  endtask

  // one compare match per action, then buffer mode
  task automatic testMatch();
    logic [3:0] codes [4] = '{4'h5, 4'h2, 4'h3, 4'h7};
    logic [3:0] bEnd = 4'b1010; // pin b after one match, codes 1 6 7 3
    xfer(8'h10, 1'b1, 32'h5);
    xfer(8'h14, 1'b1, 32'h5);
    foreach (codes[k])
    begin
      xfer(8'h00, 1'b1, {28'h0, codes[k]});
      xfer(8'h04, 1'b1, {24'h0, codes[k] ^ 4'h4, 4'h0});
      xfer(8'h18, 1'b1, 32'hf);
      xfer(8'h08, 1'b1, 32'h6);
      cyc(12);
      xfer(8'h08, 1'b1, 32'h0);
      chk(aOut, !codes[k][2]);
      chk(bOut, bEnd[k]);
      xfer(8'h18, 1'b0, 32'h0);
      chk(rd[1], 1'b1);
      chk(rd[3], 1'b1);
    end
    xfer(8'h00, 1'b1, 32'h3);
    xfer(8'h08, 1'b1, 32'h1);
    cyc(2);
    chk(aOe_b, 1'b1);
    xfer(8'h00, 1'b1, 32'h8);
    xfer(8'h18, 1'b1, 32'hf);
    setA <= 1'b1;
    cyc(6);
    xfer(8'h18, 1'b0, 32'h0);
    chk(rd[0], 1'b0);
    xfer(8'h08, 1'b1, 32'h0);
    setA <= 1'b0;
    cyc(6);
    setA <= 1'b1;
    cyc(6);
    xfer(8'h18, 1'b0, 32'h0);
    chk(rd[0], 1'b1);
    $display("match done");
  endtask

  // capture edges on pin b only
  task automatic testCapture();
    xfer(8'h04, 1'b1, 32'h0);
    setB <= 1'b1;
    cyc(4);
    for (int c = 8; c < 12; c++)
    begin
      xfer(8'h04, 1'b1, 32'(c) << 4);
      xfer(8'h18, 1'b1, 32'hf);
      setA <= ~setA;
      cyc(6);
      xfer(8'h18, 1'b0, 32'h0);
      chk(rd[2], 1'b0);
      setB <= 1'b0;
      cyc(6);
      xfer(8'h18, 1'b0, 32'h0);
      chk(rd[2], 32'(c != 8));
      xfer(8'h18, 1'b1, 32'h4);
      setB <= 1'b1;
      cyc(6);
      xfer(8'h18, 1'b0, 32'h0);
      chk(rd[2], 32'(c != 9));
    end
    $display("capture done");
  endtask

  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // main sequence
  initial
  begin
    rst_b = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    setA = 1'b0;
    setB = 1'b0;
    nMismatch = 0;
    checkCount = 0;
    cyc(6);
    rst_b <= 1'b1;
    cyc(3);
    testRegs();
    testInit();
    testMatch();
    testCapture();
    completeRun();
  end
endmodule

`default_nettype wire
